// *** tmr8_pkg.sv ***
package tmr8_pkg;
  // register indices on the plain register port
  localparam logic [2:0] ADDR_CONTROL_A = 3'h0;
  localparam logic [2:0] ADDR_COUNT = 3'h1;
  localparam logic [2:0] ADDR_COMPARE_A = 3'h2;
  localparam logic [2:0] ADDR_IRQ_MASK = 3'h3;
  localparam logic [2:0] ADDR_IRQ_FLAGS = 3'h4;
  // control register fields
  localparam int CTL_FORCE_BIT = 7;
  localparam int CTL_WGM_HI_BIT = 6;
  localparam int CTL_COM_HI_BIT = 5;
  localparam int CTL_COM_LO_BIT = 4;
  localparam int CTL_WGM_LO_BIT = 3;
  localparam int CTL_CS_HI_BIT = 2;
  // mask and flag fields
  localparam int CMP_BIT = 1;
  localparam int OVF_BIT = 0;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;
  localparam logic [7:0] COUNT_ONE = 8'h01;
  // waveform modes
  localparam logic [1:0] WGM_NORMAL = 2'h0;
  localparam logic [1:0] WGM_PHASE_PWM = 2'h1;
  localparam logic [1:0] WGM_CLEAR_ON_MATCH = 2'h2;
  localparam logic [1:0] WGM_FAST_PWM = 2'h3;
  // output modes
  localparam logic [1:0] COM_OFF = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;
  // clock select codes
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  // prescaler tap bits (divide by 2**(bit+1))
  localparam int PRE_WIDTH = 10;
  localparam int TAP8 = 2;
  localparam int TAP64 = 5;
  localparam int TAP256 = 7;
  localparam int TAP1024 = 9;
endpackage

// *** tmr8_prescale.sv ***
`timescale 1ns/1ps
module tmr8_prescale
  import tmr8_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [2:0] clock_select_field,
  output logic tick_int
);
  import tmr8_pkg::*;
  logic [PRE_WIDTH-1:0] pre_r;
  logic [PRE_WIDTH-1:0] pre_nxt;
  logic [PRE_WIDTH-1:0] wrap;
  always_comb begin
    pre_nxt = pre_r + {{(PRE_WIDTH-1){1'b0}}, 1'b1};
    wrap = pre_r & ~pre_nxt;
  end
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_nxt;
    end
  end
  // one-cycle tick per tap period
  always_comb begin
    unique case (clock_select_field)
      CS_DIV1: tick_int = 1'b1;
      CS_DIV8: tick_int = wrap[TAP8];
      CS_DIV64: tick_int = wrap[TAP64];
      CS_DIV256: tick_int = wrap[TAP256];
      CS_DIV1024: tick_int = wrap[TAP1024];
      default: tick_int = 1'b0;
    endcase
  end
endmodule // tmr8_prescale

// *** tmr8_extsync.sv ***
`timescale 1ns/1ps
module tmr8_extsync (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic external_count_pin,
  output logic rise_pulse,
  output logic fall_pulse
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= external_count_pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  always_comb begin
    rise_pulse = s2_r & ~s3_r;
    fall_pulse = ~s2_r & s3_r;
  end
endmodule // tmr8_extsync

// *** tmr8_timer.sv ***
// Summary of operation
// - force strobe acts only in non-PWM modes
// - force strobe applies output-mode action immediately
// - forced compare sets no flag, no clear
// - force strobe bit always reads zero
// - mode field at bits 6,3 selects mode
// - overflow at MAX, or BOTTOM in phase PWM
// - nonzero output mode overrides pin, direction enables
// - non-PWM: disconnect, toggle, clear, set on match
// - fast PWM: clear/set on match, opposite at BOTTOM
// - phase PWM: action flips with count direction
// - compare equals TOP in PWM: act at TOP
// - clock select: stop, divide taps, external edges
// - external pin counts even when driven as output
// - count writable; write blocks next match
// - compare register continuously matched against count
// - compare interrupt needs enable, global, flag
// - overflow interrupt needs enable, global, flag
// - compare flag set on match, cleared by ack/one
// - overflow flag cleared by ack or one written
`timescale 1ns/1ps
module tmr8_timer
  import tmr8_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic external_count_pin,
  input wire logic global_irq_enable,
  input wire logic compare_irq_ack,
  input wire logic overflow_irq_ack,
  input wire logic pin_direction,
  input wire logic port_data,
  output logic compare_output_pin,
  output logic compare_output_pin_oe,
  output logic compare_irq,
  output logic overflow_irq
);
  import tmr8_pkg::*;

  typedef enum logic [1:0] {
    TMR8_DIR_UP = 2'b01,
    TMR8_DIR_DOWN = 2'b10
  } tmr8_dir_t;

  logic [7:0] ctl_r, ctl_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic [7:0] ocr_r, ocr_nxt;
  logic [7:0] ocr_buf_r, ocr_buf_nxt;
  logic [1:0] msk_r, msk_nxt;
  logic cmp_flag_r, cmp_flag_nxt;
  logic ovf_flag_r, ovf_flag_nxt;
  logic oc_r, oc_nxt;
  logic block_r, block_nxt;
  tmr8_dir_t dir_r, dir_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic pin_r, pin_nxt;
  logic oe_r, oe_nxt;
  logic cirq_r, cirq_nxt;
  logic oirq_r, oirq_nxt;
  logic dir_sync1_r, dir_sync2_r, dat_sync1_r, dat_sync2_r;
  logic gie_sync1_r, gie_sync2_r;

  logic [1:0] wgm;
  logic [1:0] com;
  logic [2:0] csel;
  logic tick_int, ext_rise, ext_fall, tick;
  logic is_pwm, match, at_top_evt, at_bottom_evt, ovf_evt, force_evt;
  logic [1:0] wr_wgm;
  logic [1:0] wr_com;
  logic wr_ctl, wr_cnt, wr_ocr, wr_msk, wr_flg;
  logic [7:0] top;

  // synchronised level inputs: pin direction, port data, global irq enable
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      dir_sync1_r <= 1'b0;
      dir_sync2_r <= 1'b0;
      dat_sync1_r <= 1'b0;
      dat_sync2_r <= 1'b0;
      gie_sync1_r <= 1'b0;
      gie_sync2_r <= 1'b0;
    end else begin
      dir_sync1_r <= pin_direction;
      dir_sync2_r <= dir_sync1_r;
      dat_sync1_r <= port_data;
      dat_sync2_r <= dat_sync1_r;
      gie_sync1_r <= global_irq_enable;
      gie_sync2_r <= gie_sync1_r;
    end
  end

  tmr8_prescale u_pre (
    .core_clk(core_clk),
    .reset(reset),
    .clock_select_field(csel),
    .tick_int(tick_int)
  );

  tmr8_extsync u_ext (
    .core_clk(core_clk),
    .reset(reset),
    .external_count_pin(external_count_pin),
    .rise_pulse(ext_rise),
    .fall_pulse(ext_fall)
  );

  function automatic logic apply_com(input logic [1:0] c, input logic cur);
    unique case (c)
      COM_TOGGLE: apply_com = ~cur;
      COM_CLEAR: apply_com = 1'b0;
      COM_SET: apply_com = 1'b1;
      default: apply_com = cur;
    endcase
  endfunction

  function automatic logic mode_is_pwm(input logic [1:0] m);
    mode_is_pwm = (m == WGM_PHASE_PWM) || (m == WGM_FAST_PWM);
  endfunction

  always_comb begin
    wgm = {ctl_r[CTL_WGM_HI_BIT], ctl_r[CTL_WGM_LO_BIT]};
    com = ctl_r[CTL_COM_HI_BIT:CTL_COM_LO_BIT];
    csel = ctl_r[CTL_CS_HI_BIT:0];
    is_pwm = mode_is_pwm(wgm);
    wr_wgm = {reg_wdata[CTL_WGM_HI_BIT], reg_wdata[CTL_WGM_LO_BIT]};
    wr_com = reg_wdata[CTL_COM_HI_BIT:CTL_COM_LO_BIT];
    top = (wgm == WGM_CLEAR_ON_MATCH) ? ocr_r : COUNT_MAX;
    tick = tick_int | ((csel == CS_EXT_RISE) & ext_rise) | ((csel == CS_EXT_FALL) & ext_fall);
    wr_ctl = reg_write && (reg_addr == ADDR_CONTROL_A);
    wr_cnt = reg_write && (reg_addr == ADDR_COUNT);
    wr_ocr = reg_write && (reg_addr == ADDR_COMPARE_A);
    wr_msk = reg_write && (reg_addr == ADDR_IRQ_MASK);
    wr_flg = reg_write && (reg_addr == ADDR_IRQ_FLAGS);
    match = tick && (cnt_r == ocr_r) && !block_r;
    at_top_evt = tick && (cnt_r == top);
    at_bottom_evt = tick && (cnt_r == COUNT_BOTTOM);
    ovf_evt = (wgm == WGM_PHASE_PWM) ? (at_bottom_evt && dir_r == TMR8_DIR_DOWN)
                                     : (tick && cnt_r == COUNT_MAX);
    force_evt = wr_ctl && reg_wdata[CTL_FORCE_BIT] && !mode_is_pwm(wr_wgm);
  end

  // counter, direction and compare buffer
  always_comb begin
    cnt_nxt = cnt_r;
    dir_nxt = dir_r;
    ocr_nxt = ocr_r;
    ocr_buf_nxt = ocr_buf_r;
    block_nxt = block_r;
    if (tick) begin
      block_nxt = 1'b0;
      if (wgm == WGM_PHASE_PWM) begin
        if (dir_r == TMR8_DIR_UP) begin
          if (cnt_r == COUNT_MAX) begin
            dir_nxt = TMR8_DIR_DOWN;
            cnt_nxt = cnt_r - COUNT_ONE;
          end else begin
            cnt_nxt = cnt_r + COUNT_ONE;
          end
        end else if (cnt_r == COUNT_BOTTOM) begin
          dir_nxt = TMR8_DIR_UP;
          cnt_nxt = cnt_r + COUNT_ONE;
        end else begin
          cnt_nxt = cnt_r - COUNT_ONE;
        end
      end else if (cnt_r == top) begin
        cnt_nxt = COUNT_BOTTOM;
        dir_nxt = TMR8_DIR_UP;
      end else begin
        cnt_nxt = cnt_r + COUNT_ONE;
        dir_nxt = TMR8_DIR_UP;
      end
    end
    if (wr_ocr) begin
      ocr_buf_nxt = reg_wdata;
    end
    if (!is_pwm) begin
      ocr_nxt = wr_ocr ? reg_wdata : ocr_buf_r;
    end else if ((wgm == WGM_PHASE_PWM && at_top_evt) || (wgm == WGM_FAST_PWM && at_top_evt)) begin
      ocr_nxt = ocr_buf_r;
    end
    if (wr_cnt) begin
      cnt_nxt = reg_wdata;
      block_nxt = 1'b1;
    end
  end

  // waveform output
  always_comb begin
    oc_nxt = oc_r;
    unique case (wgm)
      WGM_FAST_PWM: begin
        if (com[1]) begin
          if (ocr_r == COUNT_MAX) begin
            if (at_top_evt) oc_nxt = ~com[0];
          end else if (match) begin
            oc_nxt = com[0];
          end else if (at_top_evt) begin
            oc_nxt = ~com[0];
          end
        end
      end
      WGM_PHASE_PWM: begin
        if (com[1]) begin
          if (ocr_r == COUNT_MAX) begin
            if (at_top_evt) oc_nxt = ~com[0];
          end else if (match) begin
            oc_nxt = (dir_r == TMR8_DIR_UP) ? com[0] : ~com[0];
          end
        end
      end
      default: begin
        if (match) begin
          oc_nxt = apply_com(com, oc_r);
        end
      end
    endcase
    if (force_evt) begin
      oc_nxt = apply_com(wr_com, oc_r);
    end
  end

  // flags, mask, control and read path
  always_comb begin
    ctl_nxt = ctl_r;
    msk_nxt = msk_r;
    cmp_flag_nxt = cmp_flag_r;
    ovf_flag_nxt = ovf_flag_r;
    if (wr_ctl) begin
      ctl_nxt = reg_wdata;
      ctl_nxt[CTL_FORCE_BIT] = 1'b0;
    end
    if (wr_msk) begin
      msk_nxt = reg_wdata[1:0];
    end
    if (compare_irq_ack || (wr_flg && reg_wdata[CMP_BIT])) begin
      cmp_flag_nxt = 1'b0;
    end
    if (overflow_irq_ack || (wr_flg && reg_wdata[OVF_BIT])) begin
      ovf_flag_nxt = 1'b0;
    end
    if (match) begin
      cmp_flag_nxt = 1'b1;
    end
    if (ovf_evt) begin
      ovf_flag_nxt = 1'b1;
    end
    rdata_nxt = BYTE_ZERO;
    if (reg_read) begin
      unique case (reg_addr)
        ADDR_CONTROL_A: rdata_nxt = ctl_r;
        ADDR_COUNT: rdata_nxt = cnt_r;
        ADDR_COMPARE_A: rdata_nxt = is_pwm ? ocr_buf_r : ocr_r;
        ADDR_IRQ_MASK: rdata_nxt = {6'h00, msk_r};
        ADDR_IRQ_FLAGS: rdata_nxt = {6'h00, cmp_flag_r, ovf_flag_r};
        default: rdata_nxt = BYTE_ZERO;
      endcase
    end
    oe_nxt = dir_sync2_r;
    pin_nxt = (com != COM_OFF) ? oc_r : dat_sync2_r;
    cirq_nxt = msk_r[CMP_BIT] && gie_sync2_r && cmp_flag_r;
    oirq_nxt = msk_r[OVF_BIT] && gie_sync2_r && ovf_flag_r;
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ctl_r <= BYTE_ZERO;
      cnt_r <= BYTE_ZERO;
      ocr_r <= BYTE_ZERO;
      ocr_buf_r <= BYTE_ZERO;
      msk_r <= 2'h0;
      cmp_flag_r <= 1'b0;
      ovf_flag_r <= 1'b0;
      oc_r <= 1'b0;
      block_r <= 1'b0;
      dir_r <= TMR8_DIR_UP;
      rdata_r <= BYTE_ZERO;
      pin_r <= 1'b0;
      oe_r <= 1'b0;
      cirq_r <= 1'b0;
      oirq_r <= 1'b0;
    end else begin
      ctl_r <= ctl_nxt;
      cnt_r <= cnt_nxt;
      ocr_r <= ocr_nxt;
      ocr_buf_r <= ocr_buf_nxt;
      msk_r <= msk_nxt;
      cmp_flag_r <= cmp_flag_nxt;
      ovf_flag_r <= ovf_flag_nxt;
      oc_r <= oc_nxt;
      block_r <= block_nxt;
      dir_r <= dir_nxt;
      rdata_r <= rdata_nxt;
      pin_r <= pin_nxt;
      oe_r <= oe_nxt;
      cirq_r <= cirq_nxt;
      oirq_r <= oirq_nxt;
    end
  end

  always_comb begin
    reg_rdata = rdata_r;
    compare_output_pin = pin_r;
    compare_output_pin_oe = oe_r;
    compare_irq = cirq_r;
    overflow_irq = oirq_r;
  end

  force_no_pwm_a: assert property (@(posedge core_clk) disable iff (reset)
    (wr_ctl && reg_wdata[CTL_FORCE_BIT] && mode_is_pwm(wr_wgm) && !tick) |=> (oc_r == $past(oc_r)))
    else $error("force acted in pwm mode");
  force_toggle_a: assert property (@(posedge core_clk) disable iff (reset)
    (force_evt && wr_com == COM_TOGGLE && !match) |=> (oc_r != $past(oc_r)))
    else $error("forced toggle missing");
  force_no_flag_a: assert property (@(posedge core_clk) disable iff (reset)
    (force_evt && !match && !cmp_flag_r && !tick) |=> !cmp_flag_r)
    else $error("force set compare flag");
  force_reads_zero_a: assert property (@(posedge core_clk) disable iff (reset)
    (reg_read && reg_addr == ADDR_CONTROL_A) |=> !reg_rdata[CTL_FORCE_BIT])
    else $error("force bit read as one");
  ovf_sets_flag_a: assert property (@(posedge core_clk) disable iff (reset)
    ovf_evt |=> ovf_flag_r)
    else $error("overflow flag not set");
  pin_enable_a: assert property (@(posedge core_clk) disable iff (reset)
    compare_output_pin_oe == $past(dir_sync2_r))
    else $error("pin enable mismatch");
  count_write_a: assert property (@(posedge core_clk) disable iff (reset)
    wr_cnt |=> (cnt_r == $past(reg_wdata)) ##0 !match)
    else $error("count write lost or match not blocked");
  cmp_irq_a: assert property (@(posedge core_clk) disable iff (reset)
    (msk_r[CMP_BIT] && gie_sync2_r && cmp_flag_r) |=> compare_irq)
    else $error("compare interrupt missing");
  ovf_irq_a: assert property (@(posedge core_clk) disable iff (reset)
    (msk_r[OVF_BIT] && gie_sync2_r && ovf_flag_r) |=> overflow_irq)
    else $error("overflow interrupt missing");
  flag_clear_a: assert property (@(posedge core_clk) disable iff (reset)
    (wr_flg && reg_wdata[OVF_BIT] && !ovf_evt) |=> !ovf_flag_r)
    else $error("overflow flag not cleared");
  fast_top_action_a: assert property (@(posedge core_clk) disable iff (reset)
    (wgm == WGM_FAST_PWM && com[1] && ocr_r == COUNT_MAX && at_top_evt && !force_evt) |=> (oc_r == ~$past(com[0])))
    else $error("fast pwm top action wrong");
  phase_up_match_a: assert property (@(posedge core_clk) disable iff (reset)
    (wgm == WGM_PHASE_PWM && com[1] && ocr_r != COUNT_MAX && match && dir_r == TMR8_DIR_UP && !force_evt)
    |=> (oc_r == $past(com[0])))
    else $error("phase pwm up match action wrong");
  cmp_flag_set_a: assert property (@(posedge core_clk) disable iff (reset)
    match |=> cmp_flag_r)
    else $error("compare flag not set");
  stop_holds_count_a: assert property (@(posedge core_clk) disable iff (reset)
    (csel == CS_STOP && !wr_cnt) |=> (cnt_r == $past(cnt_r)))
    else $error("stopped counter moved");
endmodule // tmr8_timer

// *** tmr8_timer_bench.sv ***
`timescale 1ns/1ps
module tmr8_timer_bench;
  import tmr8_pkg::*;
  logic core_clk, reset, reg_write, reg_read, external_count_pin, global_irq_enable;
  logic compare_irq_ack, overflow_irq_ack, pin_direction, port_data;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rv;
  logic compare_output_pin, compare_output_pin_oe, compare_irq, overflow_irq;
  int err_total, compares, hi_cnt;

  tmr8_timer u_tmr8_timer (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .external_count_pin(external_count_pin),
    .global_irq_enable(global_irq_enable), .compare_irq_ack(compare_irq_ack), .overflow_irq_ack(overflow_irq_ack),
    .pin_direction(pin_direction), .port_data(port_data), .compare_output_pin(compare_output_pin),
    .compare_output_pin_oe(compare_output_pin_oe), .compare_irq(compare_irq), .overflow_irq(overflow_irq));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  function automatic logic [7:0] ctl(input logic [1:0] wgm, input logic [1:0] com, input logic [2:0] cs,
    input logic frc);
    ctl = {frc, wgm[1], com, wgm[0], cs};
  endfunction

  function automatic logic sig(input int sel);
    case (sel)
      0: sig = compare_irq;
      1: sig = overflow_irq;
      default: sig = compare_output_pin;
    endcase
  endfunction

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_in(input string what, input int lo, input int hi, input logic [9:0] got);
    compares++;
    if ($isunknown(got) || got < lo || got > hi) begin
      err_total++;
      $display("wrong value %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    @(negedge core_clk);
    v = reg_rdata;
  endtask

  task automatic wait_sig(input int sel, input logic v, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      @(negedge core_clk);
      if (sig(sel) === v) break;
    end
    compares++;
    if (i == lim) begin
      err_total++;
      $display("wrong value output %0d expected %b seen %b", sel, v, sig(sel));
      test_done();
    end
  endtask

  task automatic run_duty(input logic [1:0] wgm, input logic [1:0] com, input logic [7:0] cmp, input int n,
    input int lo, input int hi);
    wr(ADDR_CONTROL_A, ctl(WGM_NORMAL, COM_OFF, CS_STOP, 1'b0));
    wr(ADDR_COMPARE_A, cmp);
    wr(ADDR_COUNT, 8'h00);
    wr(ADDR_CONTROL_A, ctl(wgm, com, CS_DIV1, 1'b0));
    cyc(600);
    hi_cnt = 0;
    repeat (n) begin
      @(negedge core_clk);
      if (compare_output_pin === 1'b1) hi_cnt++;
    end
    chk_in("pwm high cycles", lo, hi, hi_cnt[9:0]);
  endtask

  task automatic run_count(input logic [2:0] cs, input int n, input int lo, input int hi);
    wr(ADDR_CONTROL_A, ctl(WGM_NORMAL, COM_OFF, CS_STOP, 1'b0));
    wr(ADDR_COUNT, 8'h00);
    wr(ADDR_CONTROL_A, ctl(WGM_NORMAL, COM_OFF, cs, 1'b0));
    cyc(8 * n);
    wr(ADDR_CONTROL_A, ctl(WGM_NORMAL, COM_OFF, CS_STOP, 1'b0));
    rd(ADDR_COUNT, rv);
    chk_in("prescaled count", lo, hi, {2'b00, rv});
  endtask

  initial begin
    err_total = 0;
    compares = 0;
    reset = 1'b1;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    external_count_pin = 1'b0;
    global_irq_enable = 1'b0;
    compare_irq_ack = 1'b0;
    overflow_irq_ack = 1'b0;
    pin_direction = 1'b0;
    port_data = 1'b0;
    cyc(3);
    reset <= 1'b0;
    // reset values, unmapped index, plain read/write
    for (int a = 0; a < 6; a++) begin
      rd(a[2:0], rv);
      chk("reset value", 8'h00, rv);
    end
    wr(3'h5, 8'hFF);
    rd(3'h5, rv);
    chk("unmapped read", 8'h00, rv);
    wr(ADDR_IRQ_MASK, 8'h03);
    rd(ADDR_IRQ_MASK, rv);
    chk("mask readback", 8'h03, rv);
    $display("test registers done");
    // pin pass-through and driver enable
    cyc(1);
    port_data <= 1'b1;
    pin_direction <= 1'b1;
    cyc(5);
    chk("pin pass", 8'h01, {7'h0, compare_output_pin});
    chk("pin enable", 8'h01, {7'h0, compare_output_pin_oe});
    port_data <= 1'b0;
    pin_direction <= 1'b0;
    cyc(5);
    chk("pin pass", 8'h00, {7'h0, compare_output_pin});
    chk("pin enable", 8'h00, {7'h0, compare_output_pin_oe});
    pin_direction <= 1'b1;
    $display("test port done");
    // forced compare in stopped timer
    wr(ADDR_COMPARE_A, 8'h80);
    wr(ADDR_COUNT, 8'h30);
    wr(ADDR_CONTROL_A, ctl(WGM_NORMAL, COM_SET, CS_STOP, 1'b1));
    wait_sig(2, 1'b1, 8);
    rd(ADDR_CONTROL_A, rv);
    chk("force reads zero", ctl(WGM_NORMAL, COM_SET, CS_STOP, 1'b0), rv);
    wr(ADDR_CONTROL_A, ctl(WGM_CLEAR_ON_MATCH, COM_CLEAR, CS_STOP, 1'b1));
    wait_sig(2, 1'b0, 8);
    wr(ADDR_CONTROL_A, ctl(WGM_NORMAL, COM_TOGGLE, CS_STOP, 1'b1));
    wait_sig(2, 1'b1, 8);
    wr(ADDR_CONTROL_A, ctl(WGM_NORMAL, COM_CLEAR, CS_STOP, 1'b1));
    wait_sig(2, 1'b0, 8);
    wr(ADDR_CONTROL_A, ctl(WGM_FAST_PWM, COM_SET, CS_STOP, 1'b1));
    cyc(6);
    chk("force in fast pwm", 8'h00, {7'h0, compare_output_pin});
    wr(ADDR_CONTROL_A, ctl(WGM_PHASE_PWM, COM_SET, CS_STOP, 1'b1));
    cyc(6);
    chk("force in phase pwm", 8'h00, {7'h0, compare_output_pin});
    rd(ADDR_IRQ_FLAGS, rv);
    chk("force flags", 8'h00, rv);
    rd(ADDR_COUNT, rv);
    chk("force keeps count", 8'h30, rv);
    $display("test force done");
    // clear-on-match with compare flag and interrupt
    wr(ADDR_IRQ_MASK, 8'h02);
    global_irq_enable <= 1'b1;
    wr(ADDR_COUNT, 8'h00);
    wr(ADDR_COMPARE_A, 8'h05);
    wr(ADDR_CONTROL_A, ctl(WGM_CLEAR_ON_MATCH, COM_TOGGLE, CS_DIV1, 1'b0));
    wait_sig(0, 1'b1, 40);
    repeat (6) begin
      rd(ADDR_COUNT, rv);
      chk_in("ctc count", 0, 5, {2'b00, rv});
    end
    wr(ADDR_CONTROL_A, ctl(WGM_CLEAR_ON_MATCH, COM_TOGGLE, CS_STOP, 1'b0));
    rd(ADDR_IRQ_FLAGS, rv);
    chk("ctc flags", 8'h02, rv);
    wr(ADDR_IRQ_FLAGS, 8'h00);
    rd(ADDR_IRQ_FLAGS, rv);
    chk("zero write keeps", 8'h02, rv);
    cyc(1);
    compare_irq_ack <= 1'b1;
    cyc(1);
    compare_irq_ack <= 1'b0;
    rd(ADDR_IRQ_FLAGS, rv);
    chk("ack clears", 8'h00, rv);
    wait_sig(0, 1'b0, 8);
    $display("test compare done");
    // overflow in normal mode
    wr(ADDR_IRQ_MASK, 8'h01);
    wr(ADDR_COUNT, 8'hF8);
    wr(ADDR_CONTROL_A, ctl(WGM_NORMAL, COM_OFF, CS_DIV1, 1'b0));
    wait_sig(1, 1'b1, 40);
    wr(ADDR_CONTROL_A, ctl(WGM_NORMAL, COM_OFF, CS_STOP, 1'b0));
    cyc(1);
    global_irq_enable <= 1'b0;
    wait_sig(1, 1'b0, 8);
    global_irq_enable <= 1'b1;
    wait_sig(1, 1'b1, 8);
    wr(ADDR_IRQ_FLAGS, 8'h00);
    rd(ADDR_IRQ_FLAGS, rv);
    chk("zero write keeps", 8'h01, {7'h0, rv[0]});
    wr(ADDR_IRQ_FLAGS, 8'h01);
    rd(ADDR_IRQ_FLAGS, rv);
    chk("one write clears", 8'h00, {7'h0, rv[0]});
    wait_sig(1, 1'b0, 8);
    $display("test overflow done");
    // phase pwm overflow only at bottom
    wr(ADDR_IRQ_FLAGS, 8'h03);
    wr(ADDR_COUNT, 8'h10);
    wr(ADDR_CONTROL_A, ctl(WGM_PHASE_PWM, COM_OFF, CS_DIV1, 1'b0));
    cyc(300);
    chk("no overflow at max", 8'h00, {7'h0, overflow_irq});
    wait_sig(1, 1'b1, 300);
    wr(ADDR_IRQ_MASK, 8'h00);
    $display("test phase overflow done");
    // waveform duty per PWM mode and clear/set output mode
    run_duty(WGM_FAST_PWM, COM_CLEAR, 8'h40, 512, 122, 138);
    run_duty(WGM_FAST_PWM, COM_SET, 8'h40, 512, 374, 390);
    run_duty(WGM_FAST_PWM, COM_CLEAR, 8'hFF, 512, 500, 512);
    run_duty(WGM_PHASE_PWM, COM_CLEAR, 8'h40, 1020, 244, 268);
    run_duty(WGM_PHASE_PWM, COM_SET, 8'h40, 1020, 752, 776);
    run_duty(WGM_PHASE_PWM, COM_CLEAR, 8'hFF, 1020, 1010, 1020);
    $display("test waveform done");
    // clock select taps
    run_count(CS_STOP, 8, 0, 0);
    run_count(CS_DIV1, 1, 7, 11);
    run_count(CS_DIV8, 8, 7, 11);
    run_count(CS_DIV64, 64, 7, 11);
    run_count(CS_DIV256, 256, 7, 11);
    run_count(CS_DIV1024, 1024, 7, 11);
    $display("test prescaler done");
    // external pin edges with pin configured as output
    for (int k = 0; k < 2; k++) begin
      wr(ADDR_COUNT, 8'h00);
      wr(ADDR_CONTROL_A, ctl(WGM_NORMAL, COM_OFF, (k == 0) ? CS_EXT_RISE : CS_EXT_FALL, 1'b0));
      repeat (5) begin
        cyc(4);
        external_count_pin <= 1'b1;
        cyc(4);
        external_count_pin <= 1'b0;
      end
      cyc(6);
      wr(ADDR_CONTROL_A, ctl(WGM_NORMAL, COM_OFF, CS_STOP, 1'b0));
      rd(ADDR_COUNT, rv);
      chk("external count", 8'h05, rv);
    end
    $display("test external done");
    test_done();
  end
endmodule // tmr8_timer_bench
